// File: bench/pgc_props.sv
// pgc_props: framing checks on the link between host and device ends
// assumes link signals sampled on sys_clk, rstn async active low
`timescale 1ns/10ps
module pgc_props (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic csn,
  input wire logic sck,
  input wire logic mosi,
  input wire logic miso
);
  logic sck_r;
  logic [4:0] rises_r;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // counts sck rises within the current frame
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sck_r <= 1'b0;
      rises_r <= 5'h00;
    end else begin
      sck_r <= sck;
      if (csn) rises_r <= 5'h00;
      else if (sck && !sck_r) rises_r <= rises_r + 5'h01;
    end
  end
  sequence frame_open;
    $fell(csn);
  endsequence
  sequence frame_shut;
    $rose(csn);
  endsequence
  AST_SCK_IDLE: assert property (csn |-> !sck)
    else $error("sck active outside frame");
  AST_FRAME_LEN: assert property (frame_shut |-> rises_r == 5'h10)
    else $error("frame not 16 bits");
  AST_FRAME_BOUND: assert property (frame_open |-> ##[60:100] csn)
    else $error("frame too long");
  AST_FRAME_GAP: assert property (frame_shut |=> csn)
    else $error("no gap between frames");
  AST_MOSI_HOLD: assert property (sck && $past(sck) |-> $stable(mosi))
    else $error("mosi moved while sck high");
  AST_SCK_WIDTH: assert property ($rose(sck) |=> sck)
    else $error("sck high too short");
  AST_SCK_LOW_END: assert property (frame_shut |-> !$past(sck))
    else $error("frame closed with sck high");
  AST_NO_EXTRA: assert property ($rose(sck) |-> !csn && rises_r < 5'h10)
    else $error("extra sck edge");
  AST_MISO_IDLE: assert property (csn && $past(csn) |-> !miso)
    else $error("miso active outside frame");
endmodule

// File: bench/tb_top.sv
// tb_top: host and device ends joined by the link; registers, pins and pwm
// assumes 25 MHz sys_clk and both ends reset by rstn
`timescale 1ns/10ps
module tb_top;
  import pgc_pkg::*;
  logic sys_clk, rstn, soft_reset, host_active_mode, wk1, wk2, cmd_write, cmd_read, busy, done;
  logic fail_out_two, fail_out_three, pwm1, pwm2, hso1, hso2;
  logic [6:0] cmd_addr;
  logic [7:0] cmd_wdata, cmd_rdata, d;
  logic [3:0] event_in;
  logic [2:0] hs1, hs2;
  logic [1:0] ls_on, hs_on, wake_seen;
  logic [6:0] regs [5] = '{ADDR_PIN_ROLE, ADDR_PWM_ONE, ADDR_PWM_TWO, ADDR_RATE, ADDR_SCRATCH};
  int err_total = 0;
  int checked = 0;
  int cyc = 0;
  int n;
  pgc_link_if link ();
  pgc_host i_pgc_host (.sys_clk(sys_clk), .rstn(rstn), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
    .cmd_write(cmd_write), .cmd_read(cmd_read), .cmd_rdata(cmd_rdata), .busy(busy), .done(done), .link(link));
  pgc_dev i_pgc_dev (.sys_clk(sys_clk), .rstn(rstn), .soft_reset(soft_reset),
    .host_active_mode(host_active_mode), .event_in(event_in), .hs_cfg_one(hs1), .hs_cfg_two(hs2),
    .wake_pin_one(wk1), .wake_pin_two(wk2), .link(link), .fail_output_two(fail_out_two),
    .fail_output_three(fail_out_three),
    .low_side_on(ls_on), .high_side_on(hs_on), .wake_seen(wake_seen), .pwm_one_out(pwm1),
    .pwm_two_out(pwm2), .high_side_output_one(hso1), .high_side_output_two(hso2));
  pgc_props i_pgc_props (.sys_clk(sys_clk), .rstn(rstn), .csn(link.csn), .sck(link.sck),
    .mosi(link.mosi), .miso(link.miso));
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      err_total++;
      stop_test();
    end
  end
  task automatic stop_test();
    if (err_total == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic cmp_reg(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %0t reg got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmp_pin(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %0t level got %b exp %b", $time, got, exp);
    end
  endtask
  // one frame; returns at the falling edge of the done cycle
  task automatic xfer(input logic [6:0] a, input logic [7:0] wd, input logic wr);
    int k = 0;
    @(posedge sys_clk);
    cmd_addr <= a;
    cmd_wdata <= wd;
    cmd_write <= wr;
    cmd_read <= !wr;
    @(posedge sys_clk);
    cmd_write <= 1'b0;
    cmd_read <= 1'b0;
    do begin
      @(negedge sys_clk);
      if (k == 0) cmp_pin(busy, 1'b1);
    end while (done !== 1'b1 && ++k < 200);
    cmp_pin(done, 1'b1);
    cmp_pin(busy, 1'b0);
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] exp);
    xfer(a, 8'h00, 1'b0);
    cmp_reg(cmd_rdata, exp);
  endtask
  // fail output level expected t cycles after reset: 20/10/5/2.5% of the period
  function automatic logic exp_fo(input logic [1:0] dc, input int t);
    return (t % FO_PERIOD_CYC) < (FO_PERIOD_CYC / (5 << dc));
  endfunction
  function automatic logic [7:0] exp_val(input logic [6:0] a, input logic [7:0] v);
    return (a == ADDR_RATE) ? {5'h00, v[2], 1'b0, v[0]} : v;
  endfunction
  initial begin
    {rstn, soft_reset, wk1, wk2, cmd_write, cmd_read} = '0;
    {cmd_addr, cmd_wdata, event_in, hs1, hs2} = '0;
    host_active_mode = 1'b1;
    void'($urandom(1));
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    foreach (regs[i]) rd(regs[i], 8'h00);
    repeat (6) begin
      foreach (regs[i]) begin
        d = 8'($urandom);
        xfer(regs[i], d, 1'b1);
        rd(regs[i], exp_val(regs[i], d));
      end
      rd(7'h20 + 7'($urandom_range(31)), 8'h00);
    end
    xfer(ADDR_RATE, 8'hFF, 1'b1);
    rd(ADDR_RATE, 8'h05);
    xfer(ADDR_SCRATCH, 8'hA5, 1'b1);
    xfer(ADDR_PIN_ROLE, 8'h3C, 1'b1);
    @(posedge sys_clk);
    soft_reset <= 1'b1;
    @(posedge sys_clk);
    soft_reset <= 1'b0;
    rd(ADDR_PIN_ROLE, 8'h00);
    rd(ADDR_RATE, 8'h00);
    rd(ADDR_SCRATCH, 8'hA5);
    @(posedge sys_clk);
    host_active_mode <= 1'b0;
    xfer(ADDR_SCRATCH, 8'h5A, 1'b1);
    rd(ADDR_SCRATCH, 8'h00);
    @(posedge sys_clk);
    host_active_mode <= 1'b1;
    rd(ADDR_SCRATCH, 8'hA5);
    @(posedge sys_clk);
    event_in <= 4'h9;
    @(posedge sys_clk);
    event_in <= 4'h0;
    rd(ADDR_EVENT_STAT, 8'h09);
    rd(ADDR_EVENT_STAT, 8'h09);
    xfer(ADDR_EVENT_STAT, 8'h00, 1'b1);
    rd(ADDR_EVENT_STAT, 8'h00);
    @(posedge sys_clk);
    wk1 <= 1'b1;
    wk2 <= 1'b1;
    for (int c = 4; c < 8; c++) begin
      xfer(ADDR_PIN_ROLE, {2'h0, 3'(c), 3'(11 - c)}, 1'b1);
      repeat (420) @(negedge sys_clk);
      cmp_pin(ls_on[1], c == 6);
      cmp_pin(ls_on[0], c == 5);
      cmp_pin(hs_on[1], c == 7);
      cmp_pin(hs_on[0], c == 4);
      cmp_pin(wake_seen[0], c == 6);
      cmp_pin(wake_seen[1], c == 5);
    end
    @(posedge sys_clk);
    hs1 <= HS_FOLLOW_ONE;
    hs2 <= HS_FOLLOW_TWO;
    for (int k = 0; k < 2; k++) begin
      xfer(ADDR_RATE, 8'(k * 5), 1'b1);
      xfer(ADDR_PWM_ONE, k ? 8'h00 : 8'hFF, 1'b1);
      xfer(ADDR_PWM_TWO, k ? 8'hFF : 8'h00, 1'b1);
      repeat (4) @(negedge sys_clk);
      repeat (300) begin
        @(negedge sys_clk);
        cmp_pin(pwm1, k == 0);
        cmp_pin(pwm2, k == 1);
        cmp_pin(hso1, k == 0);
        cmp_pin(hso2, k == 1);
      end
    end
    xfer(ADDR_PWM_ONE, 8'h80, 1'b1);
    repeat (4) @(negedge sys_clk);
    n = 0;
    repeat (PWM_STEPS * PWM_FAST_DIV) begin
      @(negedge sys_clk);
      n += int'(pwm1);
    end
    cmp_pin(n == 128 * PWM_FAST_DIV, 1'b1);
    // past the 2.5% on-time, still inside the 5% one
    for (int f = 0; f < 4; f++) begin
      xfer(ADDR_PIN_ROLE, {2'(f), 3'h0, (f == 0) ? ROLE_OFF : 3'h0}, 1'b1);
      repeat (4) @(negedge sys_clk);
      cmp_pin(fail_out_three, exp_fo(2'(f), cyc));
      cmp_pin(fail_out_two, f != 0 && exp_fo(2'(f), cyc));
    end
    stop_test();
  end
endmodule

// File: core/pgc_dev.sv
// pgc_dev: device end; serial slave, config bank, two pwm channels, pin roles
// assumes link inputs synchronous to sys_clk, sampled on rising sck edges
//
// Contract
// - fail_output_duty_field bits 7:6 pick 20/10/5/2.5% duty
// - pin codes: fail out, off, wake, ls, hs
// - duty 0 off, 255 on, else fraction
// - two pwm channels, own 8-bit duty
// - rate bits 0,2: clear 200Hz, set 400Hz
// - rate reserved bits ignore writes, read 0
// - host avoids tiny nonzero duty values
// - host assigns timer when using filter
// - config and pwm regs zero on resets
// - scratch zero at power-up, survives soft reset
// - scratch survives fail-safe and restart
// - scratch access only in active mode
// - 16-bit frame: address, mode bit, data
// - data bits map to frame 8..15
// - mode bit 0 reads without change
// - mode bit 1 clears clearable bits
// - status bits latch until host clears; here soft_reset also reloads them from event_in
// - read-only bits ignore clear requests
// - one register per frame
// - hs code 100 follows pwm1, 101 pwm2
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/10ps
module pgc_dev
  import pgc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic soft_reset,
  input wire logic host_active_mode,
  input wire logic [3:0] event_in,
  input wire logic [2:0] hs_cfg_one,
  input wire logic [2:0] hs_cfg_two,
  input wire logic wake_pin_one,
  input wire logic wake_pin_two,
  pgc_link_if.dev link,
  output logic fail_output_two,
  output logic fail_output_three,
  output logic [1:0] low_side_on,
  output logic [1:0] high_side_on,
  output logic [1:0] wake_seen,
  output logic pwm_one_out,
  output logic pwm_two_out,
  output logic high_side_output_one,
  output logic high_side_output_two
);
  import pgc_pkg::*;

  logic [7:0] pin_role_config_r, pwm_one_duty_r, pwm_two_duty_r, pwm_rate_select_r, host_scratch_byte_r;
  logic [3:0] event_stat_r;
  logic sck_d_r, csn_d_r, miso_r;
  logic [4:0] bit_cnt_r;
  logic [15:0] shift_r, frame_nxt;
  logic [7:0] rdata;
  logic frame_done;

  function automatic logic [7:0] read_reg(input logic [6:0] a);
    case (a)
      ADDR_PIN_ROLE: read_reg = pin_role_config_r;
      ADDR_PWM_ONE: read_reg = pwm_one_duty_r;
      ADDR_PWM_TWO: read_reg = pwm_two_duty_r;
      ADDR_RATE: read_reg = pwm_rate_select_r & RATE_MASK;
      ADDR_SCRATCH: read_reg = host_active_mode ? host_scratch_byte_r : RESET_VAL;
      ADDR_EVENT_STAT: read_reg = {4'h0, event_stat_r};
      default: read_reg = RESET_VAL;
    endcase
  endfunction

  // frame: bits 6:0 address, bit 7 mode, bits 15:8 data, lsb first
  wire sck_rise = link.sck & ~sck_d_r;
  wire sck_fall = ~link.sck & sck_d_r;
  assign frame_nxt = {link.mosi, shift_r[15:1]};
  // address bits sit in 14:8 while the ninth bit is still pending
  assign rdata = read_reg(shift_r[14:8]);

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sck_d_r <= 1'b0;
      csn_d_r <= 1'b1;
    end else begin
      sck_d_r <= link.sck;
      csn_d_r <= link.csn;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      bit_cnt_r <= 5'h00;
      shift_r <= 16'h0000;
    end else if (link.csn) begin
      bit_cnt_r <= 5'h00;
    end else if (sck_rise && bit_cnt_r != 5'(FRAME_BITS)) begin
      shift_r <= frame_nxt;
      bit_cnt_r <= bit_cnt_r + 5'h01;
    end
  end

  // exactly 16 bits taken before csn rises commits one register
  assign frame_done = link.csn & ~csn_d_r & (bit_cnt_r == 5'(FRAME_BITS));
  wire [6:0] f_addr = shift_r[6:0];
  wire f_clr = shift_r[ACC_BIT];
  wire [7:0] f_data = shift_r[15:DATA_LSB];

  // miso: after 7 address bits and the mode bit, shift out read data lsb first
  logic [7:0] rd_byte_r;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      miso_r <= 1'b0;
      rd_byte_r <= RESET_VAL;
    end else if (link.csn) begin
      miso_r <= 1'b0;
    end else if (sck_fall && bit_cnt_r == 5'h08) begin
      rd_byte_r <= rdata;
      miso_r <= rdata[0];
    end else if (sck_fall && bit_cnt_r > 5'h08 && bit_cnt_r < 5'(FRAME_BITS)) begin
      miso_r <= rd_byte_r[3'(bit_cnt_r - 5'h08)];
    end
  end
  assign link.miso = miso_r;

  // mode bit selects write for control registers
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pin_role_config_r <= RESET_VAL;
      pwm_one_duty_r <= RESET_VAL;
      pwm_two_duty_r <= RESET_VAL;
      pwm_rate_select_r <= RESET_VAL;
    end else if (soft_reset) begin
      pin_role_config_r <= RESET_VAL;
      pwm_one_duty_r <= RESET_VAL;
      pwm_two_duty_r <= RESET_VAL;
      pwm_rate_select_r <= RESET_VAL;
    end else if (frame_done && f_clr) begin
      case (f_addr)
        ADDR_PIN_ROLE: pin_role_config_r <= f_data;
        ADDR_PWM_ONE: pwm_one_duty_r <= f_data;
        ADDR_PWM_TWO: pwm_two_duty_r <= f_data;
        ADDR_RATE: pwm_rate_select_r <= f_data & RATE_MASK;
        default: ;
      endcase
    end
  end

  // scratch only cleared by power-on reset
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      host_scratch_byte_r <= RESET_VAL;
    end else if (frame_done && f_clr && f_addr == ADDR_SCRATCH && host_active_mode) begin
      host_scratch_byte_r <= f_data;
    end
  end

  // event status: latched, set beats clear
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      event_stat_r <= 4'h0;
    end else if (soft_reset) begin
      event_stat_r <= event_in;
    end else if (frame_done && f_clr && f_addr == ADDR_EVENT_STAT) begin
      event_stat_r <= event_in;
    end else begin
      event_stat_r <= event_stat_r | event_in;
    end
  end

  // pwm channels
  logic [1:0] pwm_q;
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_pwm
      logic [16:0] pre_r;
      logic [7:0] cnt_r;
      logic [7:0] duty;
      logic fast;
      assign duty = (g == 0) ? pwm_one_duty_r : pwm_two_duty_r;
      assign fast = pwm_rate_select_r[(g == 0) ? RATE_ONE_BIT : RATE_TWO_BIT];
      always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
          pre_r <= 17'h00000;
          cnt_r <= 8'h00;
          pwm_q[g] <= 1'b0;
        end else begin
          if (pre_r >= 17'(fast ? PWM_FAST_DIV - 1 : PWM_SLOW_DIV - 1)) begin
            pre_r <= 17'h00000;
            cnt_r <= (cnt_r >= 8'(PWM_STEPS - 1)) ? 8'h00 : cnt_r + 8'h01;
          end else begin
            pre_r <= pre_r + 17'h00001;
          end
          pwm_q[g] <= (duty == 8'hFF) | (cnt_r < duty);
        end
      end
    end
  endgenerate

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pwm_one_out <= 1'b0;
      pwm_two_out <= 1'b0;
      high_side_output_one <= 1'b0;
      high_side_output_two <= 1'b0;
    end else begin
      pwm_one_out <= pwm_q[0];
      pwm_two_out <= pwm_q[1];
      high_side_output_one <= (hs_cfg_one == HS_FOLLOW_ONE) ? pwm_q[0] :
                              (hs_cfg_one == HS_FOLLOW_TWO) ? pwm_q[1] : 1'b0;
      high_side_output_two <= (hs_cfg_two == HS_FOLLOW_ONE) ? pwm_q[0] :
                              (hs_cfg_two == HS_FOLLOW_TWO) ? pwm_q[1] : 1'b0;
    end
  end

  // fail output blink with selectable duty
  logic [21:0] fo_cnt_r;
  logic [21:0] fo_on;
  always_comb begin
    case (pin_role_config_r[FO_DUTY_MSB:FO_DUTY_LSB])
      2'h0: fo_on = 22'(FO_ON_20);
      2'h1: fo_on = 22'(FO_ON_10);
      2'h2: fo_on = 22'(FO_ON_5);
      default: fo_on = 22'(FO_ON_2P5);
    endcase
  end
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      fo_cnt_r <= 22'h000000;
    end else begin
      fo_cnt_r <= (fo_cnt_r >= 22'(FO_PERIOD_CYC - 1)) ? 22'h000000 : fo_cnt_r + 22'h000001;
    end
  end
  wire fo_wave = fo_cnt_r < fo_on;

  // per-pin role decode, wake filter
  logic [1:0] wake_in;
  assign wake_in = {wake_pin_two, wake_pin_one};
  logic [1:0] fo_sel;
  generate
    for (g = 0; g < 2; g++) begin : g_pin
      logic [2:0] role;
      logic [9:0] filt_r;
      assign role = pin_role_config_r[((g == 0) ? PIN_ONE_LSB : PIN_TWO_LSB) +: 3];
      assign fo_sel[g] = ~role[2];
      always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
          filt_r <= 10'h000;
          wake_seen[g] <= 1'b0;
          low_side_on[g] <= 1'b0;
          high_side_on[g] <= 1'b0;
        end else begin
          low_side_on[g] <= (role == ROLE_LOW_SIDE);
          high_side_on[g] <= (role == ROLE_HIGH_SIDE);
          if (role != ROLE_WAKE || !wake_in[g]) begin
            filt_r <= 10'h000;
            wake_seen[g] <= 1'b0;
          end else if (filt_r >= 10'(WAKE_FILT_CYC - 1)) begin
            wake_seen[g] <= 1'b1;
          end else begin
            filt_r <= filt_r + 10'h001;
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      fail_output_two <= 1'b0;
      fail_output_three <= 1'b0;
    end else begin
      fail_output_two <= fo_sel[0] & fo_wave;
      fail_output_three <= fo_sel[1] & fo_wave;
    end
  end
endmodule

// File: core/pgc_host.sv
// pgc_host: host end; turns register commands into 16-bit serial frames
// assumes the command port is driven from sys_clk and the device samples on sck rise
`timescale 1ns/10ps
module pgc_host
  import pgc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [6:0] cmd_addr,
  input wire logic [7:0] cmd_wdata,
  input wire logic cmd_write,
  input wire logic cmd_read,
  output logic [7:0] cmd_rdata,
  output logic busy,
  output logic done,
  pgc_link_if.host link
);
  import pgc_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SHIFT = 3'b010,
    ST_END = 3'b100
  } pgc_state_e;

  pgc_state_e state_r;
  logic [15:0] tx_r;
  logic [7:0] rx_r;
  logic [4:0] bit_r;
  logic [1:0] div_r;
  logic csn_r, sck_r;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= ST_IDLE;
      tx_r <= 16'h0000;
      rx_r <= 8'h00;
      bit_r <= 5'h00;
      div_r <= 2'h0;
      csn_r <= 1'b1;
      sck_r <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
      cmd_rdata <= 8'h00;
    end else begin
      done <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (cmd_write || cmd_read) begin
            // mode bit set for write or clear access
            tx_r <= {(cmd_write ? cmd_wdata : 8'h00), cmd_write, cmd_addr};
            csn_r <= 1'b0;
            bit_r <= 5'h00;
            div_r <= 2'h0;
            busy <= 1'b1;
            state_r <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          div_r <= div_r + 2'h1;
          if (div_r == 2'(SCK_HALF - 1)) begin
            sck_r <= 1'b1;
            if (bit_r >= 5'h08) begin
              rx_r <= {link.miso, rx_r[7:1]};
            end
          end else if (div_r == 2'(2 * SCK_HALF - 1)) begin
            sck_r <= 1'b0;
            tx_r <= {1'b0, tx_r[15:1]};
            bit_r <= bit_r + 5'h01;
            if (bit_r == 5'(FRAME_BITS - 1)) begin
              state_r <= ST_END;
            end
          end
        end
        ST_END: begin
          csn_r <= 1'b1;
          busy <= 1'b0;
          done <= 1'b1;
          cmd_rdata <= rx_r;
          state_r <= ST_IDLE;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  assign link.csn = csn_r;
  assign link.sck = sck_r;
  assign link.mosi = tx_r[0];
endmodule

// File: include/pgc_link_if.sv
// pgc_link_if: four-wire serial link between host controller and device
// assumes both ends run on the same sys_clk
`timescale 1ns/10ps
interface pgc_link_if;
  logic csn;
  logic sck;
  logic mosi;
  logic miso;
  modport dev (input csn, input sck, input mosi, output miso);
  modport host (output csn, output sck, output mosi, input miso);
endinterface

// File: include/pgc_pkg.sv
// pgc_pkg: register map, frame layout and timing constants for the pin/pwm config bank
// assumes a 25 MHz system clock shared by both ends
package pgc_pkg;
  localparam int unsigned CLK_HZ = 25000000;
  localparam logic [6:0] ADDR_PIN_ROLE = 7'h17;
  localparam logic [6:0] ADDR_PWM_ONE = 7'h18;
  localparam logic [6:0] ADDR_PWM_TWO = 7'h19;
  localparam logic [6:0] ADDR_RATE = 7'h1C;
  localparam logic [6:0] ADDR_SCRATCH = 7'h1E;
  localparam logic [6:0] ADDR_EVENT_STAT = 7'h40;
  localparam logic [7:0] RESET_VAL = 8'h00;
  localparam logic [7:0] RATE_MASK = 8'h05;
  localparam int FRAME_BITS = 16;
  localparam int ACC_BIT = 7;
  localparam int DATA_LSB = 8;
  localparam int FO_DUTY_MSB = 7;
  localparam int FO_DUTY_LSB = 6;
  localparam int PIN_TWO_LSB = 3;
  localparam int PIN_ONE_LSB = 0;
  localparam int RATE_ONE_BIT = 0;
  localparam int RATE_TWO_BIT = 2;
  localparam logic [2:0] ROLE_OFF = 3'h4;
  localparam logic [2:0] ROLE_WAKE = 3'h5;
  localparam logic [2:0] ROLE_LOW_SIDE = 3'h6;
  localparam logic [2:0] ROLE_HIGH_SIDE = 3'h7;
  localparam logic [2:0] HS_FOLLOW_ONE = 3'h4;
  localparam logic [2:0] HS_FOLLOW_TWO = 3'h5;
  localparam int PWM_SLOW_HZ = 200;
  localparam int PWM_FAST_HZ = 400;
  localparam int PWM_STEPS = 255;
  localparam int PWM_SLOW_DIV = CLK_HZ / (PWM_SLOW_HZ * PWM_STEPS);
  localparam int PWM_FAST_DIV = CLK_HZ / (PWM_FAST_HZ * PWM_STEPS);
  localparam int WAKE_FILT_NS = 16000;
  localparam int WAKE_FILT_CYC = (WAKE_FILT_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int FO_PERIOD_CYC = 2500000;
  localparam int FO_ON_20 = FO_PERIOD_CYC / 5;
  localparam int FO_ON_10 = FO_PERIOD_CYC / 10;
  localparam int FO_ON_5 = FO_PERIOD_CYC / 20;
  localparam int FO_ON_2P5 = FO_PERIOD_CYC / 40;
  localparam int SCK_HALF = 2;
endpackage
